// ---- rtl/pdc_regs.svh ----
/*
 * Register offsets, field positions, reset values and bus codes of the
 * duty-compare PWM channel.
 * Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
 */
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// Register byte offsets (low address byte)
`define PDC_OFF_DUTY 8'h00
`define PDC_OFF_PERIOD 8'h04
`define PDC_OFF_COUNTER 8'h08
`define PDC_OFF_CTRL 8'h0c
`define PDC_OFF_PRESCALE 8'h10
`define PDC_OFF_STATUS 8'h14
`define PDC_OFF_MSB 7

// Control field positions
`define PDC_CTRL_EN 0
`define PDC_CTRL_POL 1

// Reset values
`define PDC_DUTY_RST 8'hff
`define PDC_PERIOD_RST 8'hff
`define PDC_PRESCALE_RST 8'h00
`define PDC_CNT_ZERO 8'h00
`define PDC_CNT_ONE 8'h01
`define PDC_WORD_ZERO 32'h0000_0000

// AHB codes
`define PDC_HTRANS_ACT 1
`define PDC_HRESP_OKAY 1'b0

`endif

// ---- rtl/pdc_pkg.sv ----
/*
 * Types shared by the duty-compare PWM files, and the register decoder.
 * Assumes the register header is on the include path.
 */
`include "pdc_regs.svh"

package pdc_pkg;
    // One data byte of the channel
    typedef logic [7:0] pdc_byte_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        PDC_REG_DUTY,
        PDC_REG_PERIOD,
        PDC_REG_COUNTER,
        PDC_REG_CTRL,
        PDC_REG_PRESCALE,
        PDC_REG_STATUS,
        PDC_REG_NONE
    } pdc_reg_t;

    // Address decode, shared by the read and the write path
    function automatic pdc_reg_t pdc_decode(input logic [`PDC_OFF_MSB:0] off);
        unique case (off)
            `PDC_OFF_DUTY: pdc_decode = PDC_REG_DUTY;
            `PDC_OFF_PERIOD: pdc_decode = PDC_REG_PERIOD;
            `PDC_OFF_COUNTER: pdc_decode = PDC_REG_COUNTER;
            `PDC_OFF_CTRL: pdc_decode = PDC_REG_CTRL;
            `PDC_OFF_PRESCALE: pdc_decode = PDC_REG_PRESCALE;
            `PDC_OFF_STATUS: pdc_decode = PDC_REG_STATUS;
            default: pdc_decode = PDC_REG_NONE;
        endcase
    endfunction
endpackage

// ---- rtl/pdc_channel.sv ----
/*
 * One left-aligned PWM channel: double-buffered duty and period, the
 * channel counter and the compare that drives the output.
 * Assumes one clock, a one-cycle tick enable for the channel clock and
 * one-cycle write strobes from the register block.
 */
`timescale 1ns/1ps
`include "pdc_regs.svh"

module pdc_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Channel clock enable
    input wire logic tick,
    // Settings
    input wire logic enable,
    input wire logic polarity,
    // Write strobes and data
    input wire logic wr_duty,
    input wire logic wr_period,
    input wire logic wr_counter,
    input wire pdc_pkg::pdc_byte_t wdata,
    // State seen by software
    output pdc_pkg::pdc_byte_t duty_buf,
    output pdc_pkg::pdc_byte_t duty_act,
    output pdc_pkg::pdc_byte_t period_buf,
    output pdc_pkg::pdc_byte_t period_act,
    output pdc_pkg::pdc_byte_t count,
    // Channel output
    output logic out
);
    logic enable_d; // Enable seen last cycle
    logic disable_evt; // Enable just fell
    logic period_end; // Counter wraps on this tick
    logic update_evt; // Buffers move to the latches
    pdc_pkg::pdc_byte_t next_count; // Count after this tick

    // Falling enable detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_d <= 1'b0;
        end else begin
            enable_d <= enable;
        end
    end

    assign disable_evt = enable_d && !enable;
    // RULE_11 wrap at period minus one
    assign period_end = enable && tick && (count == period_act - `PDC_CNT_ONE);
    assign next_count = period_end ? `PDC_CNT_ZERO : count + `PDC_CNT_ONE;
    // RULE_03 update events gathered
    assign update_evt = period_end || wr_counter || disable_evt;

    // Holding buffers always take the newest software value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_buf <= `PDC_DUTY_RST;
            period_buf <= `PDC_PERIOD_RST;
        end else begin
            // RULE_02 writes land in buffer
            if (wr_duty) begin
                duty_buf <= wdata;
            end
            if (wr_period) begin
                period_buf <= wdata;
            end
        end
    end

    // Active latches: straight through while disabled, else on events
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_act <= `PDC_DUTY_RST;
            period_act <= `PDC_PERIOD_RST;
        end else begin
            // RULE_06 disabled write goes through
            if (wr_duty && !enable) begin
                duty_act <= wdata;
            // RULE_04 RULE_05 load on event
            end else if (update_evt) begin
                duty_act <= duty_buf;
            end
            // RULE_12 period follows same events
            if (wr_period && !enable) begin
                period_act <= wdata;
            end else if (update_evt) begin
                period_act <= period_buf;
            end
        end
    end

    // Counter and output; a wrap also restarts the waveform
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= `PDC_CNT_ZERO;
            out <= 1'b0;
        end else if (wr_counter) begin
            // RULE_04 RULE_12 clear and restart
            count <= `PDC_CNT_ZERO;
            out <= polarity;
        // RULE_13 hold while disabled
        end else if (enable && tick) begin
            // RULE_14 compare on channel tick
            count <= next_count;
            if (period_end) begin
                // RULE_08 RULE_09 start level
                out <= polarity;
            // RULE_01 match toggles output
            end else if (next_count == duty_act) begin
                out <= !out;
            end
        end
    end
endmodule

// ---- rtl/pdc_top.sv ----
/*
 * Duty-compare PWM channel with its AHB-Lite register block and the
 * prescaler that makes the channel clock enable.
 * Assumes a single AHB-Lite master, word transfers only, and pins that
 * are synchronous to REF_CLK.
 */
//
// Behaviour
// RULE_01 - Duty match with counter toggles output
// RULE_02 - Enabled duty writes go to buffer only
// RULE_03 - Period end loads buffered duty
// RULE_04 - Counter write clears count, loads duty
// RULE_05 - Disabling channel loads buffered duty
// RULE_06 - Disabled duty write loads both copies
// RULE_07 - Duty read returns last written value
// RULE_08 - Polarity one: start high, low on match
// RULE_09 - Polarity zero: start low, high on match
// RULE_10 - High fraction follows duty and polarity
// RULE_11 - Counter runs zero to period minus one
// RULE_12 - Counter write sets up, loads, restarts
// RULE_13 - Disabled channel counter holds
// RULE_14 - Compare runs on channel clock tick
`timescale 1ns/1ps
`include "pdc_regs.svh"

module pdc_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // AHB-Lite address phase
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    // AHB-Lite data phase
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Channel output
    output logic PWM_OUT
);

    // Bus side state

    // A write waits here for its data phase
    logic wr_pend;

    // Register picked by the pending write
    pdc_pkg::pdc_reg_t wr_sel;

    // Register picked by the current address phase
    pdc_pkg::pdc_reg_t addr_sel;

    // Address phase accepted this cycle
    logic addr_take;

    // Software settings

    // Channel enable bit
    logic channel_enable_bit;

    // Output start level
    logic output_start_level;

    // Channel clock divider setting
    pdc_pkg::pdc_byte_t prescale;

    // Divider count
    pdc_pkg::pdc_byte_t presc_cnt;

    // One-cycle channel clock enable
    logic tick;

    // Data-phase write strobes

    // Duty register written
    logic wr_duty;

    // Period register written
    logic wr_period;

    // Counter written
    logic wr_counter;

    // Low byte of the write data
    pdc_pkg::pdc_byte_t wbyte;

    // Channel state

    // Last duty written by software
    pdc_pkg::pdc_byte_t channel_duty_value;

    // Duty in use by the compare
    pdc_pkg::pdc_byte_t duty_act;

    // Last period written by software
    pdc_pkg::pdc_byte_t channel_period_value;

    // Period in use by the counter
    pdc_pkg::pdc_byte_t period_act;

    // Channel counter
    pdc_pkg::pdc_byte_t channel_counter;

    // Read data for the next data phase
    logic [31:0] next_rdata;

    // Address phase decode

    // A transfer is taken only when selected, active and the bus is ready
    assign addr_take = HSEL && HTRANS[`PDC_HTRANS_ACT] && HREADY;

    // Only the low byte of the address picks a register
    assign addr_sel = pdc_pkg::pdc_decode(HADDR[`PDC_OFF_MSB:0]);

    // Write data uses the low byte lane only
    assign wbyte = HWDATA[7:0];

    // Write strobes are single pulses in the data phase
    assign wr_duty = wr_pend && (wr_sel == pdc_pkg::PDC_REG_DUTY);
    assign wr_period = wr_pend && (wr_sel == pdc_pkg::PDC_REG_PERIOD);

    // RULE_04 any counter write value
    assign wr_counter = wr_pend && (wr_sel == pdc_pkg::PDC_REG_COUNTER);

    // Remember a write so its data can be used one cycle later
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            wr_pend <= 1'b0;
            wr_sel <= pdc_pkg::PDC_REG_NONE;
        end else begin
            // Idle or unselected cycles clear the pending write
            wr_pend <= addr_take && HWRITE;
            if (addr_take) begin
                wr_sel <= addr_sel;
            end
        end
    end

    // Handshake outputs

    // No wait states are ever inserted, and every answer is OKAY.
    // Kept in flops so the outputs are clean from reset onward.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= `PDC_HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= `PDC_HRESP_OKAY;
        end
    end

    // Read multiplexer

    // Unmapped offsets read as zero; narrow fields sit in the low bits
    always_comb begin
        next_rdata = `PDC_WORD_ZERO;
        unique case (addr_sel)
            pdc_pkg::PDC_REG_DUTY: begin
                // RULE_07 read returns buffer
                next_rdata[7:0] = channel_duty_value;
            end
            pdc_pkg::PDC_REG_PERIOD: begin
                // Same buffered readback as the duty
                next_rdata[7:0] = channel_period_value;
            end
            pdc_pkg::PDC_REG_COUNTER: begin
                // Reading does not disturb the count
                next_rdata[7:0] = channel_counter;
            end
            pdc_pkg::PDC_REG_CTRL: begin
                next_rdata[`PDC_CTRL_EN] = channel_enable_bit;
                next_rdata[`PDC_CTRL_POL] = output_start_level;
            end
            pdc_pkg::PDC_REG_PRESCALE: begin
                next_rdata[7:0] = prescale;
            end
            pdc_pkg::PDC_REG_STATUS: begin
                // Active copies, so software can see a pending update
                next_rdata[7:0] = duty_act;
                next_rdata[15:8] = period_act;
            end
            pdc_pkg::PDC_REG_NONE: begin
                next_rdata = `PDC_WORD_ZERO;
            end
        endcase
    end

    // Read data register

    // Sampled at the address phase so HRDATA comes from a flop in the
    // data phase. Trade-off: a read right behind a write to the same
    // register sees the old value; the bus master here always idles
    // between transfers, so this never shows.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            HRDATA <= `PDC_WORD_ZERO;
        end else if (addr_take && !HWRITE) begin
            HRDATA <= next_rdata;
        end
    end

    // Control register

    // Enable and start level, written in the data phase
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            channel_enable_bit <= 1'b0;
            output_start_level <= 1'b0;
        end else if (wr_pend && (wr_sel == pdc_pkg::PDC_REG_CTRL)) begin
            channel_enable_bit <= HWDATA[`PDC_CTRL_EN];
            // RULE_08 RULE_09 start level stored
            output_start_level <= HWDATA[`PDC_CTRL_POL];
        end
    end

    // Prescale register

    // A new setting also restarts the divider so the first channel
    // tick after the change has the full new length
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            prescale <= `PDC_PRESCALE_RST;
        end else if (wr_pend && (wr_sel == pdc_pkg::PDC_REG_PRESCALE)) begin
            prescale <= wbyte;
        end
    end

    // Channel clock divider

    // Tick once every prescale plus one cycles; zero gives every cycle.
    // The divider runs freely so that enabling the channel does not
    // shift its clock phase.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            presc_cnt <= `PDC_CNT_ZERO;
            tick <= 1'b0;
        end else if (wr_pend && (wr_sel == pdc_pkg::PDC_REG_PRESCALE)) begin
            // Restart on a new setting
            presc_cnt <= `PDC_CNT_ZERO;
            tick <= 1'b0;
        end else if (presc_cnt == prescale) begin
            // RULE_14 channel tick produced
            presc_cnt <= `PDC_CNT_ZERO;
            tick <= 1'b1;
        end else begin
            presc_cnt <= presc_cnt + `PDC_CNT_ONE;
            tick <= 1'b0;
        end
    end

    // Channel

    // The compare stage owns the buffers, latches, counter and output.
    // RULE_10 duty fraction from compare
    pdc_channel u_channel (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .tick(tick),
        .enable(channel_enable_bit),
        .polarity(output_start_level),
        .wr_duty(wr_duty),
        .wr_period(wr_period),
        .wr_counter(wr_counter),
        .wdata(wbyte),
        .duty_buf(channel_duty_value),
        .duty_act(duty_act),
        .period_buf(channel_period_value),
        .period_act(period_act),
        .count(channel_counter),
        .out(PWM_OUT)
    );

endmodule

// ---- test/pdc_chk_asserts.sv ----
/* Checker for the PWM duty block: bus answers and output level.
   Assumes it is bound to pdc_top with one master on the bus. */
`timescale 1ns/1ps
module pdc_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Output
    input wire logic PWM_OUT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    logic acc; // Address phase taken
    logic rd_acc; // Read taken
    logic cw; // Counter write lands now
    logic dp_wr; // Write in data phase
    logic en_s; // Shadow of enable
    logic pol_s; // Shadow of start level
    logic clr; // Count known to be zero
    logic [7:0] dp_off; // Offset of data phase
    logic [7:0] duty_s; // Last written duty
    assign acc = HSEL && HTRANS[1] && HREADY;
    assign rd_acc = acc && !HWRITE;
    assign cw = dp_wr && dp_off == 8'h08;
    // Shadow of software writes, committed at the end of the data phase
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            dp_wr <= 1'b0;
            dp_off <= 8'h00;
            duty_s <= 8'hff;
            en_s <= 1'b0;
            pol_s <= 1'b0;
            clr <= 1'b1;
        end else begin
            dp_wr <= acc && HWRITE;
            dp_off <= HADDR[7:0];
            // An enabled count moves, so zero is only known while stopped
            if (en_s) begin
                clr <= 1'b0;
            end
            if (dp_wr && dp_off == 8'h00) begin
                duty_s <= HWDATA[7:0];
            end
            if (cw && !en_s) begin
                clr <= 1'b1;
            end
            if (dp_wr && dp_off == 8'h0c) begin
                en_s <= HWDATA[0];
                pol_s <= HWDATA[1];
                clr <= clr && !HWDATA[0];
            end
        end
    end
    property p_ready; HREADYOUT == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; HRESP == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_rst; $rose(RESET_N) |-> PWM_OUT == 1'b0 && HRDATA == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_hold; !rd_acc |=> $stable(HRDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rd_duty; rd_acc && HADDR[7:0] == 8'h00 |=> HRDATA == {24'h0, $past(duty_s)};
    endproperty
    a_rd_duty: assert property (p_rd_duty) else $error("duty read wrong");
    property p_rd_unm; rd_acc && HADDR[7:0] >= 8'h18 |=> HRDATA == 32'h0; endproperty
    a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
    property p_cw; cw |=> PWM_OUT == pol_s; endproperty
    a_cw: assert property (p_cw) else $error("counter write level wrong");
    property p_dis; !en_s && !cw |=> $stable(PWM_OUT); endproperty
    a_dis: assert property (p_dis) else $error("output moved while stopped");
    property p_cnt; rd_acc && HADDR[7:0] == 8'h08 && clr |=> HRDATA == 32'h0; endproperty
    a_cnt: assert property (p_cnt) else $error("cleared count not zero");
    c_cw: cover property (cw && en_s);
    c_rise: cover property (en_s && $rose(PWM_OUT));
    c_rd: cover property (rd_acc && HADDR[7:0] == 8'h14);
endmodule
bind pdc_top pdc_chk u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PWM_OUT(PWM_OUT));

// ---- test/pwm_duty_compare_buffer_test.sv ----
/* Bench for the PWM duty block: register tasks and output counts.
   Assumes pdc_top, a zero wait slave, and the checker bound beside it. */
`timescale 1ns/1ps
module pwm_duty_compare_buffer_test;
    logic ref_clk = 1'b0; // 100 MHz clock
    logic reset_n = 1'b0; // Held low at start
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready; // One slave, so its ready is the bus ready
    logic [31:0] hrdata;
    logic hreadyout;
    logic pwm_out;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    assign hready = hreadyout;
    pdc_top dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hready),
        .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(),
        .PWM_OUT(pwm_out));
    // Clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single transfer; read data taken at the end of the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // High cycles in 8, i.e. two whole periods of 4 at any phase
    task automatic hi8(input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0;
        repeat (8) begin
            @(negedge ref_clk);
            n = n + {31'h0, pwm_out === 1'b1};
        end
        chk(n, exp);
    endtask
    // Main sequence
    initial begin
        logic [31:0] q;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(8'h00, 32'hff);
        rd(8'h08, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h14, 32'hffff);
        wr(8'h00, 32'h1);
        rd(8'h14, 32'hff01);
        wr(8'h04, 32'h4);
        wr(8'h0c, 32'h3);
        // Enabling alone does not load the start level; a counter write starts the period
        wr(8'h08, 32'h0);
        hi8(32'h2);
        // Count must stay below the period
        repeat (4) begin
            bus(1'b0, 8'h08, 32'h0, q);
            chk({31'h0, q < 32'h4}, 32'h1);
        end
        wr(8'h0c, 32'h1);
        wr(8'h08, 32'h0);
        hi8(32'h6);
        // Slow ticks so one period outlasts several transfers
        wr(8'h10, 32'h3f);
        wr(8'h0c, 32'h3);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h3);
        rd(8'h14, 32'h0401);
        rd(8'h00, 32'h3);
        repeat (330) @(posedge ref_clk);
        rd(8'h14, 32'h0403);
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h0);
        rd(8'h14, 32'h0402);
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h0);
        // Latch loads one edge after enable clears
        @(posedge ref_clk);
        rd(8'h14, 32'h0401);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h0);
        finish_test;
    end
endmodule
